// file: rtl/apl_axis_position_limits.sv
// axis position supervision: wrap, software limits, encoder type
`timescale 1ns/1ns
`include "apl_regs.svh"
module apl_axis_position_limits (
  input  wire logic                 mclk,
  input  wire logic                 reset_n,
  input  wire logic                 cfg_load,
  input  wire apl_pkg::apl_cfg_type cfg_in,
  input  wire logic                 move_valid,
  input  wire logic signed [31:0]   move_delta,
  input  wire logic                 zero_set,
  input  wire logic                 zero_lost,
  input  wire logic                 alarm_clear,
  output logic signed [31:0]        position,
  output logic                      zero_established,
  output apl_pkg::apl_stat_type     status,
  output apl_pkg::apl_enc_type      encoder_type
);
  import apl_pkg::*;

  // ******************************
  // configuration
  // ******************************
  apl_cfg_type cfg_q, cfg_d;
  logic        zero_q, zero_d;
  logic signed [31:0] pos_q, pos_d;
  apl_stat_type stat_q, stat_d;

  // wrap maximum zero or negative is refused, keeping the old one
  logic wrap_ok;
  assign wrap_ok = (cfg_in.wrap_max != 32'h0) && !cfg_in.wrap_max[31];

  // next configuration
  always_comb begin
    cfg_d = cfg_q;
    if (cfg_load) begin
      cfg_d = cfg_in;
      if (!wrap_ok) cfg_d.wrap_max = cfg_q.wrap_max;
    end
  end

  // ******************************
  // position and limits
  // ******************************
  // one bit wider than the position so that a step cannot overflow the sum
  logic signed [32:0] target;
  logic signed [32:0] wmax;
  logic               infinite;
  logic               fwd_hit;
  logic               rev_hit;
  // decoded setting bits and the sum of position and step
  assign infinite = cfg_q.func_sel[`APL_FUNC_INFINITE_BIT];
  assign wmax     = {1'b0, cfg_q.wrap_max};
  assign target   = 33'(pos_q) + 33'(move_delta);

  // forward overrun, gated by enable, only after zero
  assign fwd_hit = move_valid && !move_delta[31] && (move_delta != 32'h0) && zero_q
                   && cfg_q.func_sel[`APL_FUNC_FWD_EN_BIT] && !infinite
                   && (target > 33'(signed'(cfg_q.fwd_limit)));
  // reverse overrun, gated by enable, only after zero
  assign rev_hit = move_valid && move_delta[31] && zero_q
                   && cfg_q.func_sel[`APL_FUNC_REV_EN_BIT] && !infinite
                   && (target < 33'(signed'(cfg_q.rev_limit)));

  // next position, zero flag and alarms; a refused move leaves position alone
  always_comb begin
    pos_d  = pos_q;
    zero_d = zero_q;
    stat_d = stat_q;
    if (alarm_clear) begin
      stat_d.fwd_alarm = 1'b0;
      stat_d.rev_alarm = 1'b0;
    end
    stat_d.cfg_error = stat_q.cfg_error | (cfg_load & !wrap_ok);
    // set wins over clear
    if (fwd_hit) stat_d.fwd_alarm = 1'b1;
    if (rev_hit) stat_d.rev_alarm = 1'b1;
    if (zero_lost) zero_d = 1'b0;
    if (zero_set) begin
      zero_d = 1'b1;
      pos_d  = 32'sh0;
    end else if (move_valid && !fwd_hit && !rev_hit) begin
      if (infinite) begin
        // wrap within zero..max, steps assumed below max
        if (target > wmax) pos_d = 32'(target - wmax - 33'sd1);
        else if (target < 33'sd0) pos_d = 32'(target + wmax + 33'sd1);
        else pos_d = 32'(target);
      end else begin
        pos_d = 32'(target);
      end
    end
  end

  // ******************************
  // registers
  // ******************************
  // reset defaults
  // configuration group: only a load or a reset changes it, so the limits
  // and the wrap maximum hold steady between loads
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      cfg_q.func_sel  <= 3'h0;
      cfg_q.wrap_max  <= `APL_WRAP_MAX_DEFAULT;
      cfg_q.fwd_limit <= `APL_FWD_LIMIT_DEFAULT;
      cfg_q.rev_limit <= `APL_REV_LIMIT_DEFAULT;
      cfg_q.enc_sel   <= `APL_ENC_DEFAULT;
    end else begin
      cfg_q <= cfg_d;
    end
  end

  // zero point lost on reset
  // motion group: position, zero flag and sticky alarms
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      zero_q <= 1'b0;
      pos_q  <= 32'sh0;
      stat_q <= '0;
    end else begin
      zero_q <= zero_d;
      pos_q  <= pos_d;
      stat_q <= stat_d;
    end
  end

  // outputs straight from the flip-flops, no logic after them
  assign position         = pos_q;
  assign zero_established = zero_q;
  assign status           = stat_q;
  // encoder type decode
  // reserved code 3 is passed through; the controller must not rely on it
  assign encoder_type     = apl_enc_type'(cfg_q.enc_sel);

  // ******************************
  // checks
  // ******************************
  // range holds while a step stays within one turn of the counter
  chk_wrap_range: assert property (@(posedge mclk) disable iff (!reset_n)
    infinite && !cfg_load && pos_q >= 0 && pos_q <= wmax
    && (!move_valid || (target <= wmax + wmax + 33'sd1 && target >= -wmax - 33'sd1))
    |=> pos_q >= 0 && pos_q <= wmax)
    else $error("wrapped position left range");

  // a refused maximum keeps the old one and leaves an error
  chk_wrap_refuse: assert property (@(posedge mclk) disable iff (!reset_n)
    cfg_load && !wrap_ok |=> cfg_q.wrap_max == $past(cfg_q.wrap_max) && stat_q.cfg_error)
    else $error("bad wrap maximum taken");

  // the configuration error stays until reset
  chk_cfg_sticky: assert property (@(posedge mclk) disable iff (!reset_n)
    stat_q.cfg_error |=> stat_q.cfg_error)
    else $error("configuration error dropped");

  // reset defaults: widest limits, default maximum, incremental encoder
  chk_reset_defaults: assert property (@(posedge mclk)
    !reset_n |=> cfg_q.fwd_limit == `APL_FWD_LIMIT_DEFAULT
    && cfg_q.rev_limit == `APL_REV_LIMIT_DEFAULT && cfg_q.wrap_max == `APL_WRAP_MAX_DEFAULT
    && encoder_type == APL_ENC_INCREMENTAL)
    else $error("reset defaults wrong");

  // a forward hit raises the alarm and refuses the move
  chk_fwd_alarm: assert property (@(posedge mclk) disable iff (!reset_n)
    fwd_hit && !zero_set |=> stat_q.fwd_alarm && pos_q == $past(pos_q))
    else $error("forward alarm missing");

  // a move short of both limits is taken whole
  chk_move_apply: assert property (@(posedge mclk) disable iff (!reset_n)
    move_valid && !infinite && !fwd_hit && !rev_hit && !zero_set |=> pos_q == $past(32'(target)))
    else $error("move not applied");

  // with forward checking off a clear alarm stays clear
  chk_fwd_gate: assert property (@(posedge mclk) disable iff (!reset_n)
    !cfg_q.func_sel[`APL_FUNC_FWD_EN_BIT] && !stat_q.fwd_alarm |=> !stat_q.fwd_alarm)
    else $error("forward checked while disabled");

  // a reverse hit raises the alarm and refuses the move
  chk_rev_alarm: assert property (@(posedge mclk) disable iff (!reset_n)
    rev_hit && !zero_set |=> stat_q.rev_alarm && pos_q == $past(pos_q))
    else $error("reverse alarm missing");

  // with reverse checking off a clear alarm stays clear
  chk_rev_gate: assert property (@(posedge mclk) disable iff (!reset_n)
    !cfg_q.func_sel[`APL_FUNC_REV_EN_BIT] && !stat_q.rev_alarm |=> !stat_q.rev_alarm)
    else $error("reverse checked while disabled");

  // before a zero point neither alarm can rise
  chk_zero_gate: assert property (@(posedge mclk) disable iff (!reset_n)
    !zero_q && !stat_q.fwd_alarm && !stat_q.rev_alarm
    |=> !stat_q.fwd_alarm && !stat_q.rev_alarm)
    else $error("alarm without zero point");

  // zero point setting forces the counter to zero
  chk_zero_set: assert property (@(posedge mclk) disable iff (!reset_n)
    zero_set |=> zero_q && pos_q == 0)
    else $error("zero point not set");

  // losing the zero point drops the flag unless it is set again
  chk_zero_lost: assert property (@(posedge mclk) disable iff (!reset_n)
    zero_lost && !zero_set |=> !zero_q)
    else $error("zero point not lost");

  // clear drops the forward alarm unless a new hit lands with it
  chk_fwd_clear: assert property (@(posedge mclk) disable iff (!reset_n)
    alarm_clear && !fwd_hit |=> !stat_q.fwd_alarm)
    else $error("forward alarm not cleared");

  // clear drops the reverse alarm unless a new hit lands with it
  chk_rev_clear: assert property (@(posedge mclk) disable iff (!reset_n)
    alarm_clear && !rev_hit |=> !stat_q.rev_alarm)
    else $error("reverse alarm not cleared");

  // a load takes the encoder type in the next cycle
  chk_enc_load: assert property (@(posedge mclk) disable iff (!reset_n)
    cfg_load |=> encoder_type == $past(cfg_in.enc_sel))
    else $error("encoder type not loaded");

  // a step just past the maximum lands on zero
  chk_wrap_fwd: assert property (@(posedge mclk) disable iff (!reset_n)
    move_valid && infinite && !zero_set && target == wmax + 1 |=> pos_q == 0)
    else $error("forward wrap not to zero");

  // a step just below zero lands on the maximum
  chk_wrap_rev: assert property (@(posedge mclk) disable iff (!reset_n)
    move_valid && infinite && !zero_set && target == -1
    |=> pos_q == $past(signed'(cfg_q.wrap_max)))
    else $error("reverse wrap not to max");
endmodule

// file: rtl/apl_regs.svh
// constants for the axis position limit block
// Behaviour
// - infinite axis keeps position in zero..max
// - rotary max range 1..2^31-1, default 360000
// - forward overrun raises positive limit alarm
// - forward check only when enable bit set
// - reverse overrun raises negative limit alarm
// - reverse check only when enable bit set
// - signed 32-bit limits, extreme defaults
// - limits inactive until zero point established
// - encoder type 0..3 decode, default 0
`ifndef APL_REGS_SVH
`define APL_REGS_SVH
`define APL_FUNC_INFINITE_BIT 0
`define APL_FUNC_FWD_EN_BIT   1
`define APL_FUNC_REV_EN_BIT   2
`define APL_WRAP_MAX_DEFAULT  32'h00057e40
`define APL_FWD_LIMIT_DEFAULT 32'h7fffffff
`define APL_REV_LIMIT_DEFAULT 32'h80000000
`define APL_ENC_DEFAULT       2'h0
`endif

// file: rtl/apl_pkg.sv
// types for the axis position limit block
package apl_pkg;
  typedef enum logic [1:0] {
    APL_ENC_INCREMENTAL = 2'h0,
    APL_ENC_ABSOLUTE    = 2'h1,
    APL_ENC_ABS_AS_INC  = 2'h2,
    APL_ENC_RESERVED    = 2'h3
  } apl_enc_type;

  typedef struct packed {
    logic [2:0]  func_sel;
    logic [31:0] wrap_max;
    logic [31:0] fwd_limit;
    logic [31:0] rev_limit;
    logic [1:0]  enc_sel;
  } apl_cfg_type;

  typedef struct packed {
    logic        fwd_alarm;
    logic        rev_alarm;
    logic        cfg_error;
  } apl_stat_type;
endpackage

// file: verif/apl_drive_model.sv
// drive-side model: turns bench step requests into one-cycle moves
`timescale 1ns/1ns
module apl_drive_model (
  input  wire logic               mclk,
  input  wire logic               req,
  input  wire logic signed [31:0] req_delta,
  output logic                    move_valid,
  output logic signed [31:0]      move_delta
);
  // idle cycles invert the held delta each cycle, so the stale value and its inverse alternate while move_valid is low
  always_ff @(posedge mclk) begin
    move_valid <= req;
    move_delta <= req ? req_delta : ~move_delta;
  end
endmodule

// file: verif/tb_top.sv
// self-checking bench for the axis position limit block
`timescale 1ns/1ns
module tb_top;
  import apl_pkg::*;
  logic mclk = 0, reset_n = 0, cfg_load = 0, zero_set = 0, zero_lost = 0, alarm_clear = 0;
  logic               req = 0, move_valid, zero_established;
  logic signed [31:0] req_delta = '0, position, move_delta;
  apl_cfg_type        cfg_in = '0;
  apl_stat_type       status;
  apl_enc_type        encoder_type;
  int     fails = 0, check_count = 0, inf = 0, fen = 0, ren = 0, zero = 0, fa = 0, ra = 0, ce = 0;
  longint mx = 360000, fl = 2147483647, rl = -2147483648, pos = 0;
  always #5 mclk = ~mclk;
  apl_drive_model drv_u (.mclk(mclk), .req(req), .req_delta(req_delta),
    .move_valid(move_valid), .move_delta(move_delta));
  apl_axis_position_limits dut_u (.mclk(mclk), .reset_n(reset_n), .cfg_load(cfg_load),
    .cfg_in(cfg_in), .move_valid(move_valid), .move_delta(move_delta), .zero_set(zero_set),
    .zero_lost(zero_lost), .alarm_clear(alarm_clear), .position(position),
    .zero_established(zero_established), .status(status), .encoder_type(encoder_type));
  task chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", n, exp, seen);
    end
  endtask
  // compare position, zero flag and status against the integer model
  task settle;
    chk("position", position, pos[31:0]);
    chk("zero_established", zero_established, zero);
    chk("fwd_alarm", status.fwd_alarm, fa);
    chk("rev_alarm", status.rev_alarm, ra);
    chk("cfg_error", status.cfg_error, ce);
  endtask
  task cfg(input longint f, input longint m, input longint a, input longint b, input longint e);
    @(posedge mclk) cfg_load <= 1;
    cfg_in <= '{f[2:0], m[31:0], a[31:0], b[31:0], e[1:0]};
    @(posedge mclk) cfg_load <= 0;
    #1;
    inf = f[0];
    fen = f[1];
    ren = f[2];
    fl  = a;
    rl  = b;
    if (m >= 1 && m < 64'h80000000) mx = m;
    else ce = 1;
    chk("encoder_type", encoder_type, e[31:0]);
    settle();
  endtask
  // one move through the drive model; the integer model here predicts wrap or refusal
  task mv(input longint d);
    longint t;
    @(posedge mclk) req <= 1;
    req_delta <= d[31:0];
    @(posedge mclk) req <= 0;
    @(posedge mclk) #1;
    t = pos + d;
    if (inf) pos = t > mx ? t - mx - 1 : (t < 0 ? t + mx + 1 : t);
    else if (zero && fen && d > 0 && t > fl) fa = 1;
    else if (zero && ren && d < 0 && t < rl) ra = 1;
    else pos = t;
    settle();
  endtask
  // w: 0 zero point set, 1 zero point lost, 2 alarm clear
  task pulse(input int w);
    @(posedge mclk) case (w)
      0: zero_set <= 1;
      1: zero_lost <= 1;
      default: alarm_clear <= 1;
    endcase
    @(posedge mclk) {zero_set, zero_lost, alarm_clear} <= 3'h0;
    #1;
    case (w)
      0: {zero, pos} = {32'sd1, 64'sd0};
      1: zero = 0;
      default: {fa, ra} = 0;
    endcase
    settle();
  endtask
  task report_and_stop;
    if (fails == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    void'($urandom(32'h84d30a94));
    repeat (12) @(posedge mclk);
    reset_n <= 1;
    @(posedge mclk) #1;
    settle();
    chk("encoder_type", encoder_type, 0);
    cfg(1, 0, 0, 0, 0);
    mv(-1);
    mv(1);
    for (int e = 0; e < 4; e++) cfg(1, 100, 0, 0, e);
    repeat (40) mv(longint'($urandom_range(200)) - 100);
    mv(100 - pos);
    mv(1);
    mv(-1);
    cfg(6, 0, 50, -50, 0);
    pulse(1);
    mv(200);
    pulse(0);
    mv(50);
    mv(1);
    mv(-101);
    pulse(2);
    cfg(0, 100, 50, -50, 0);
    mv(10);
    mv(-120);
    cfg(6, 100, 50, -50, 0);
    pulse(1);
    mv(-1);
    report_and_stop();
  end
endmodule
